// file: rtl/dram_refresh_control.sv
// CBR and self-refresh engine for DRAM banks 2 and 3, AHB-Lite registers
`timescale 1ns/10ps
module dram_refresh_control (
  // System clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // AHB-Lite slave
  input  wire dram_refresh_pkg::ahb_req_t ahb_in,
  output      dram_refresh_pkg::ahb_rsp_t ahb_out,
  // Time-base count clock, one pulse per period
  input  wire logic                       time_base_tick,
  // Memory controller status
  input  wire dram_refresh_pkg::mem_in_t  mem_in,
  // DRAM strobes and status
  output      dram_refresh_pkg::mem_out_t mem_out
);
  import dram_refresh_pkg::*;

  rf_state_t s;
  rf_state_t n;

  logic       tick_hit;
  logic       cbr_due;
  logic       sr_want;
  logic       sr_keep;
  logic       addr_ok;
  logic [7:0] wbyte;

  // True when the tick closes a period of 2^(sel+1) ticks
  function automatic logic div_hit(input logic [7:0] pre, input logic [2:0] sel);
    logic [7:0] mask;
    mask = 8'hFF >> (3'h7 - sel);
    return (pre & mask) == mask;
  endfunction

  // Register read view, unimplemented bits forced low
  function automatic logic [31:0] reg_read(input rf_state_t st, input logic [31:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      OFF_COUNTDOWN: d = {24'h00_0000, st.countdown};
      OFF_RELOAD:    d = {24'h00_0000, st.reload};
      OFF_TIMING:    d = {24'h00_0000, st.timing & MASK_TIMING};
      OFF_CONTROL:   d = {24'h00_0000, st.control & MASK_CONTROL};
      default:       d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  assign tick_hit = time_base_tick & div_hit(s.prescale, s.control[SEL_LSB +: 3]); // RULE_05
  assign cbr_due  = s.counting & (s.countdown == 8'h00) & (s.control[1:0] != 2'b00); // RULE_03
  assign sr_want  = s.control[IMM_SR_BIT]
                  | (s.control[STOP_SR_BIT] & mem_in.stop_mode); // RULE_08 RULE_09
  // Once in, stop-mode entry holds until software or a DRAM access or bus release clears the bit
  assign sr_keep  = s.control[IMM_SR_BIT] | s.control[STOP_SR_BIT]; // RULE_10
  assign addr_ok  = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready;
  assign wbyte    = ahb_in.hwdata[7:0];

  always_comb begin
    n = s;

    // Divider runs on every time-base tick
    if (time_base_tick) begin
      n.prescale = s.prescale + 8'h01;
    end

    // Countdown holds at zero until the refresh is served
    if (s.counting && (s.countdown != 8'h00) && tick_hit) begin
      n.countdown = s.countdown - 8'h01; // RULE_01
    end

    // DRAM access or bus release acknowledge drops both self-refresh bits
    if (mem_in.dram_access || mem_in.bus_release_ack) begin
      n.control[STOP_SR_BIT] = 1'b0; // RULE_11
      n.control[IMM_SR_BIT]  = 1'b0; // RULE_11
    end

    // Strobe sequencer
    unique case (s.phase)
      ST_IDLE: begin
        if (sr_want) begin
          n.phase                     = ST_SELF;
          n.pins.column_strobe_n      = 1'b0; // RULE_08
          n.pins.row_strobe_n         = 1'b0;
          n.pins.self_refresh_active  = 1'b1;
        end else if (cbr_due && !mem_in.dram_busy) begin // RULE_15
          n.phase                 = ST_CBR_CAS;
          n.timer                 = CBR_CAS_CYCLES - 3'h1;
          n.pins.column_strobe_n  = 1'b0; // RULE_03
          n.pins.refresh_banks    = s.control[1:0]; // RULE_06
          n.pins.cbr_active       = 1'b1;
        end
      end
      ST_CBR_CAS: begin
        if (s.timer == 3'h0) begin
          n.phase             = ST_CBR_RAS;
          n.timer             = CBR_RAS_CYCLES - 3'h1;
          n.pins.row_strobe_n = 1'b0;
        end else begin
          n.timer = s.timer - 3'h1;
        end
      end
      ST_CBR_RAS: begin
        if (s.timer == 3'h0) begin
          n.phase                = ST_IDLE;
          n.pins.column_strobe_n = 1'b1;
          n.pins.row_strobe_n    = 1'b1;
          n.pins.refresh_banks   = 2'b00;
          n.pins.cbr_active      = 1'b0;
          n.countdown            = s.reload; // RULE_04
        end else begin
          n.timer = s.timer - 3'h1;
        end
      end
      ST_SELF: begin
        // Exit raises the row strobe first, column held for the hold time
        if (!sr_keep) begin // RULE_10
          n.phase             = ST_EXIT_HOLD;
          n.timer             = {1'b0, s.timing[HOLD_LSB +: 2]}; // RULE_12
          n.pins.row_strobe_n = 1'b1;
        end
      end
      ST_EXIT_HOLD: begin
        if (s.timer == 3'h0) begin
          n.phase                = ST_EXIT_PRE;
          n.timer                = s.timing[PRECHG_LSB +: 3]; // RULE_13
          n.pins.column_strobe_n = 1'b1;
        end else begin
          n.timer = s.timer - 3'h1;
        end
      end
      ST_EXIT_PRE: begin
        // No new cycle until the precharge time has passed
        if (s.timer == 3'h0) begin
          n.phase                    = ST_IDLE;
          n.pins.self_refresh_active = 1'b0;
        end else begin
          n.timer = s.timer - 3'h1;
        end
      end
    endcase

    // Data phase write; software setting a bit beats the hardware clear
    if (s.wr_pend) begin
      unique case (s.wr_addr)
        OFF_COUNTDOWN: n.countdown = wbyte;
        OFF_RELOAD:    n.reload    = wbyte;
        OFF_TIMING:    n.timing    = wbyte & MASK_TIMING; // RULE_14
        OFF_CONTROL: begin
          n.control = wbyte & MASK_CONTROL; // RULE_14
          // Bank field is written once; later changes are unsupported
          if (wbyte[1:0] != 2'b00) begin // RULE_07
            n.counting  = 1'b1; // RULE_02
            n.countdown = s.reload; // RULE_02
          end else begin
            n.counting = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Address phase; zero wait states, read data from the updated view
    n.wr_pend = addr_ok & ahb_in.hwrite;
    if (addr_ok) begin
      n.wr_addr = {ahb_in.haddr[31:2], 2'b00};
    end
    if (addr_ok && !ahb_in.hwrite) begin
      n.rsp.hrdata = reg_read(n, {ahb_in.haddr[31:2], 2'b00}); // RULE_14
    end
    n.rsp.hreadyout = 1'b1;
    n.rsp.hresp     = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s                          <= '0;
      s.countdown                <= RST_COUNTDOWN;
      s.reload                   <= RST_RELOAD;
      s.timing                   <= RST_TIMING;
      s.control                  <= RST_CONTROL;
      s.phase                    <= ST_IDLE;
      s.rsp.hreadyout            <= 1'b1;
      s.pins.column_strobe_n     <= 1'b1;
      s.pins.row_strobe_n        <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign ahb_out = s.rsp;
  assign mem_out = s.pins;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic wr_ctrl;
  assign wr_ctrl = s.wr_pend && (s.wr_addr == OFF_CONTROL);

  sequence cbr_enter;
    (s.phase == ST_IDLE) && cbr_due && !mem_in.dram_busy && !sr_want;
  endsequence

  sequence cbr_ras_last;
    (s.phase == ST_CBR_RAS) && (s.timer == 3'h0);
  endsequence

  sequence self_leave;
    (s.phase == ST_SELF) && !sr_keep;
  endsequence

  sequence cbr_pulse;
    (!s.pins.column_strobe_n && s.pins.row_strobe_n)
      ##1 (!s.pins.column_strobe_n && !s.pins.row_strobe_n) [*2]
      ##1 (s.pins.column_strobe_n && s.pins.row_strobe_n);
  endsequence

  a_cbr_start_strobes: assert property ( // RULE_03
    cbr_enter |=> !s.pins.column_strobe_n && s.pins.row_strobe_n
                  ##1 !s.pins.column_strobe_n && !s.pins.row_strobe_n)
    else $error("CBR refresh did not drive CAS then RAS");

  a_cbr_busy_wait: assert property ( // RULE_15
    (s.phase == ST_IDLE) && mem_in.dram_busy |=> s.phase != ST_CBR_CAS)
    else $error("CBR refresh started during a DRAM access");

  a_cbr_reload_count: assert property ( // RULE_04
    (cbr_ras_last and !s.wr_pend) |=> (s.countdown == $past(s.reload))
                                   && s.pins.row_strobe_n && s.pins.column_strobe_n)
    else $error("Counter not reloaded after CBR refresh");

  a_bank_start_load: assert property ( // RULE_02
    wr_ctrl && (wbyte[1:0] != 2'b00) |=> s.counting && (s.countdown == $past(s.reload)))
    else $error("Bank field write did not load the counter");

  a_count_decrement: assert property ( // RULE_01
    s.counting && (s.countdown != 8'h00) && tick_hit && !s.wr_pend
      && (s.phase != ST_CBR_RAS) |=> s.countdown == $past(s.countdown) - 8'h01)
    else $error("Counter did not step down on a selected tick");

  a_count_hold_idle: assert property ( // RULE_05
    s.counting && !time_base_tick && !s.wr_pend && (s.phase != ST_CBR_RAS)
      |=> $stable(s.countdown))
    else $error("Counter moved without a time-base tick");

  a_no_bank_no_cbr: assert property ( // RULE_06
    (s.phase == ST_IDLE) && (s.control[1:0] == 2'b00) |=> s.phase != ST_CBR_CAS)
    else $error("CBR refresh ran with no bank selected");

  a_self_immediate: assert property ( // RULE_08
    (s.phase == ST_IDLE) && s.control[IMM_SR_BIT]
      |=> !s.pins.column_strobe_n && !s.pins.row_strobe_n)
    else $error("Immediate self-refresh did not lower both strobes");

  a_self_stop_mode: assert property ( // RULE_09
    (s.phase == ST_IDLE) && s.control[STOP_SR_BIT] && mem_in.stop_mode
      |=> (s.phase == ST_SELF) && s.pins.self_refresh_active)
    else $error("Stop mode did not enter self-refresh");

  a_self_cancel: assert property ( // RULE_10
    (s.phase == ST_SELF) && !s.control[STOP_SR_BIT] && !s.control[IMM_SR_BIT]
      |=> s.phase == ST_EXIT_HOLD)
    else $error("Cleared enables did not end self-refresh");

  a_hw_bit_clear: assert property ( // RULE_11
    (mem_in.dram_access || mem_in.bus_release_ack) && !wr_ctrl
      |=> (s.control[STOP_SR_BIT] == 1'b0) && (s.control[IMM_SR_BIT] == 1'b0))
    else $error("Self-refresh bits survived a bank access");

  a_exit_cas_hold: assert property ( // RULE_12
    (self_leave and (s.timing[HOLD_LSB +: 2] == 2'b01))
      |=> (s.pins.row_strobe_n && !s.pins.column_strobe_n) [*2] ##1 s.pins.column_strobe_n)
    else $error("CAS hold on self-refresh exit is wrong");

  a_exit_precharge: assert property ( // RULE_13
    (s.phase == ST_EXIT_HOLD) && (s.timer == 3'h0) && (s.timing[PRECHG_LSB +: 3] == 3'h2)
      |=> (s.phase == ST_EXIT_PRE) [*3] ##1 (s.phase == ST_IDLE))
    else $error("Precharge on self-refresh exit is wrong");

  a_reserved_zero: assert property ( // RULE_14
    (s.rsp.hrdata[31:8] == 24'h00_0000) && (s.control[7] == 1'b0)
      && ((s.timing & ~MASK_TIMING) == 8'h00))
    else $error("Unimplemented bits read as one");

  a_self_hold_bits: assert property ( // RULE_10
    (s.phase == ST_SELF) && sr_keep
      |=> (s.phase == ST_SELF) && !s.pins.column_strobe_n && !s.pins.row_strobe_n)
    else $error("Self-refresh ended while an enable bit was set");

  a_stop_leave_hold: assert property ( // RULE_10
    (s.phase == ST_SELF) && s.control[STOP_SR_BIT] && !mem_in.stop_mode
      |=> s.phase == ST_SELF)
    else $error("Leaving stop mode ended self-refresh before software cleared it");

  a_cbr_strobe_run: assert property ( // RULE_03
    $rose(s.pins.cbr_active) |-> cbr_pulse)
    else $error("CBR strobe sequence has the wrong shape");

  a_cbr_banks_clear: assert property ( // RULE_06
    cbr_ras_last |=> (s.pins.refresh_banks == 2'b00) && !s.pins.cbr_active)
    else $error("Bank select not released after CBR refresh");

  a_cbr_banks_set: assert property ( // RULE_06
    s.pins.cbr_active |-> s.pins.refresh_banks != 2'b00)
    else $error("CBR refresh running with no bank driven");

  a_timing_write_mask: assert property ( // RULE_14
    s.wr_pend && (s.wr_addr == OFF_TIMING)
      |=> s.timing == ($past(wbyte) & MASK_TIMING))
    else $error("Timing register kept an unimplemented bit");

  a_control_write_mask: assert property ( // RULE_14
    wr_ctrl |=> s.control == ($past(wbyte) & MASK_CONTROL))
    else $error("Control write not stored as masked");

  a_bank_zero_stop: assert property ( // RULE_02
    wr_ctrl && (wbyte[1:0] == 2'b00) |=> !s.counting)
    else $error("Clearing the bank field left the counter running");

  a_count_zero_hold: assert property ( // RULE_03
    s.counting && (s.countdown == 8'h00) && !s.wr_pend && (s.phase != ST_CBR_RAS)
      |=> s.countdown == 8'h00)
    else $error("Counter left zero before the refresh was served");

  a_div_skip_tick: assert property ( // RULE_05
    s.counting && time_base_tick && !s.prescale[0] && !s.wr_pend
      && (s.control[SEL_LSB +: 3] == 3'h0) && (s.phase != ST_CBR_RAS)
      |=> $stable(s.countdown))
    else $error("Counter stepped on a tick that the divider should skip");

  a_exit_ras_first: assert property ( // RULE_12
    (s.phase == ST_EXIT_HOLD) |-> s.pins.row_strobe_n && !s.pins.column_strobe_n)
    else $error("Column strobe rose before the row strobe on exit");

  a_exit_flag_held: assert property ( // RULE_13
    (s.phase == ST_EXIT_HOLD) || (s.phase == ST_EXIT_PRE)
      |-> s.pins.self_refresh_active && !s.pins.cbr_active)
    else $error("Self-refresh flag dropped before precharge ended");

  a_self_flag_set: assert property ( // RULE_08
    (s.phase == ST_SELF) |-> s.pins.self_refresh_active && !s.pins.cbr_active)
    else $error("Self-refresh flag not set in self-refresh");

endmodule

// file: rtl/dram_refresh_pkg.sv
// Constants, carriers and state layout of the DRAM refresh engine
//
// Operation
// (RULE_01) 8-bit counter counts down per selected tick
// (RULE_02) Bank bit write loads counter, starts counting
// (RULE_03) Counter at zero starts CBR refresh
// (RULE_04) After CBR refresh, reload and restart count
// (RULE_05) Clock select n divides tick by 2^(n+1)
// (RULE_06) Bank field picks none, 2, 3, both
// (RULE_07) Software must not change bank field later
// (RULE_08) Immediate bit holds both strobes low; clear ends
// (RULE_09) Stop-mode bit plus stop holds strobes low
// (RULE_10) Clearing stop-mode bit ends self-refresh
// (RULE_11) Bank access or bus release clears bits
// (RULE_12) CAS hold on exit is code+1 cycles
// (RULE_13) CAS-to-RAS precharge is code+1 cycles
// (RULE_14) Unimplemented bits read back as zero
// (RULE_15) Refresh waits for running DRAM access
package dram_refresh_pkg;

  // Register byte offsets
  localparam logic [31:0] OFF_COUNTDOWN = 32'h0000_0000;
  localparam logic [31:0] OFF_RELOAD    = 32'h0000_0004;
  localparam logic [31:0] OFF_TIMING    = 32'h0000_0008;
  localparam logic [31:0] OFF_CONTROL   = 32'h0000_000C;

  // Values after reset
  localparam logic [7:0] RST_COUNTDOWN = 8'hFF;
  localparam logic [7:0] RST_RELOAD    = 8'hFF;
  localparam logic [7:0] RST_TIMING    = 8'h37;
  localparam logic [7:0] RST_CONTROL   = 8'h00;

  // Implemented bits
  localparam logic [7:0] MASK_TIMING  = 8'h37;
  localparam logic [7:0] MASK_CONTROL = 8'h7F;

  // Field positions
  localparam int SEL_LSB     = 4;
  localparam int STOP_SR_BIT = 3;
  localparam int IMM_SR_BIT  = 2;
  localparam int HOLD_LSB    = 4;
  localparam int PRECHG_LSB  = 0;

  // CBR strobe phases, in system clock cycles
  localparam logic [2:0] CBR_CAS_CYCLES = 3'h1;
  localparam logic [2:0] CBR_RAS_CYCLES = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CBR_CAS, ST_CBR_RAS, ST_SELF, ST_EXIT_HOLD, ST_EXIT_PRE
  } phase_t;

  typedef struct packed {
    logic        hsel;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } ahb_rsp_t;

  typedef struct packed {
    logic stop_mode;
    logic dram_busy;
    logic dram_access;
    logic bus_release_ack;
  } mem_in_t;

  typedef struct packed {
    logic       column_strobe_n;
    logic       row_strobe_n;
    logic [1:0] refresh_banks;
    logic       cbr_active;
    logic       self_refresh_active;
  } mem_out_t;

  typedef struct packed {
    logic [7:0]  countdown;
    logic [7:0]  reload;
    logic [7:0]  timing;
    logic [7:0]  control;
    logic        counting;
    logic [7:0]  prescale;
    phase_t      phase;
    logic [2:0]  timer;
    logic        wr_pend;
    logic [31:0] wr_addr;
    ahb_rsp_t    rsp;
    mem_out_t    pins;
  } rf_state_t;

endpackage

// file: bench/dram_bank_model.sv
// Behavioural DRAM on banks 2 and 3, counting the CBR refreshes seen on its strobes
`timescale 1ns/10ps
module dram_bank_model (
  // Clock, reset and strobes
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic column_strobe_n,
  input  wire logic row_strobe_n,
  // Refreshes seen
  output int        cbr_count
);
  logic cas_q;

  // CAS falling while RAS still high marks one CBR refresh
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cbr_count <= 0;
      cas_q     <= 1'b1;
    end else begin
      if (cas_q && !column_strobe_n && row_strobe_n) cbr_count <= cbr_count + 1;
      cas_q <= column_strobe_n;
    end
  end
endmodule

// file: bench/dram_refresh_control_test.sv
// Self-checking bench for the DRAM refresh engine
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch at %0t got %h exp %h", $time, (a), (e)); end end
module dram_refresh_control_test;
  import dram_refresh_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        tick = 1'b0;
  logic        tick_en;
  ahb_req_t    req;
  ahb_req_t    req_w;
  ahb_rsp_t    ahb_out;
  mem_in_t     mem_in;
  mem_out_t    mem_out;
  logic [31:0] rdata;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cbr_count;
  int          n;

  always #50 hclk = ~hclk;
  // Time-base pulse every other cycle, gated so a count can be frozen
  always @(posedge hclk) tick <= tick_en & ~tick;
  always_comb begin
    req_w        = req;
    req_w.hready = ahb_out.hreadyout;
  end

  dram_refresh_control dut (.hclk(hclk), .hresetn(hresetn), .ahb_in(req_w), .ahb_out(ahb_out),
    .time_base_tick(tick), .mem_in(mem_in), .mem_out(mem_out));
  dram_bank_model dram (.hclk(hclk), .hresetn(hresetn), .column_strobe_n(mem_out.column_strobe_n),
    .row_strobe_n(mem_out.row_strobe_n), .cbr_count(cbr_count));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic rst();
    @(posedge hclk);
    hresetn <= 1'b0;
    tick_en <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    req.hsel   <= 1'b1;
    req.htrans <= 2'b10;
    req.hwrite <= w;
    req.haddr  <= a;
    req.hsize  <= 3'b010;
    do @(posedge hclk); while (ahb_out.hreadyout !== 1'b1);
    req.hsel   <= 1'b0;
    req.htrans <= 2'b00;
    req.hwdata <= d;
    do @(posedge hclk); while (ahb_out.hreadyout !== 1'b1);
    rdata = ahb_out.hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(rdata, {24'h00_0000, e})
    `CHK(ahb_out.hresp, 1'b0)
  endtask

  // Waits on falling edges so registered outputs have settled
  task automatic wait_cbr(input logic v);
    n = 0;
    while (mem_out.cbr_active !== v && n < 3000) begin
      @(negedge hclk);
      n++;
    end
    if (n >= 3000) miscompares++;
  endtask

  task automatic strobes(input logic [1:0] e);
    @(negedge hclk);
    @(negedge hclk);
    `CHK({mem_out.column_strobe_n, mem_out.row_strobe_n}, e)
    @(posedge hclk);
  endtask

  task automatic exit_check(input logic [7:0] t);
    int c1;
    int c2;
    c1 = 0;
    c2 = 0;
    @(negedge hclk);
    while (mem_out.row_strobe_n !== 1'b1 && c1 < 20) begin
      @(negedge hclk);
      c1++;
    end
    c1 = 0;
    while (mem_out.column_strobe_n === 1'b0 && c1 < 20) begin
      c1++;
      @(negedge hclk);
    end
    while (mem_out.self_refresh_active === 1'b1 && c2 < 20) begin
      c2++;
      @(negedge hclk);
    end
    `CHK(c1, int'(t[5:4]) + 1)
    `CHK(c2, int'(t[2:0]) + 1)
    @(posedge hclk);
  endtask

  initial begin
    #(100 * 20000);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    hresetn = 1'b0;
    tick_en = 1'b0;
    req     = '0;
    mem_in  = '0;
    rst();
    rd(OFF_COUNTDOWN, 8'hFF);
    rd(OFF_RELOAD, 8'hFF);
    rd(OFF_TIMING, 8'h37);
    rd(OFF_CONTROL, 8'h00);
    wr(OFF_TIMING, 8'hFF);
    rd(OFF_TIMING, 8'h37);
    wr(OFF_CONTROL, 8'hF0);
    rd(OFF_CONTROL, 8'h70);
    rd(32'h0000_0010, 8'h00);
    // Fresh reset per code keeps the bank field written only once
    for (int k = 0; k < 8; k++) begin
      logic [1:0] bank;
      bank = 2'(k % 3 + 1);
      rst();
      wr(OFF_RELOAD, 8'h02);
      wr(OFF_CONTROL, {1'b0, 3'(k), 2'b00, bank});
      rd(OFF_COUNTDOWN, 8'h02);
      tick_en <= 1'b1;
      wait_cbr(1'b1);
      `CHK(n >= (4 << k) && n <= (8 << k) + 8, 1'b1)
      `CHK(mem_out.refresh_banks, bank)
      `CHK({mem_out.column_strobe_n, mem_out.row_strobe_n}, 2'b01)
      @(posedge hclk);
      tick_en <= 1'b0;
      wait_cbr(1'b0);
      @(posedge hclk);
      rd(OFF_COUNTDOWN, 8'h02);
      tick_en <= 1'b1;
      wait_cbr(1'b1);
      wait_cbr(1'b0);
      `CHK(cbr_count, 2)
    end
    rst();
    wr(OFF_RELOAD, 8'h01);
    wr(OFF_CONTROL, 8'h01);
    mem_in.dram_busy <= 1'b1;
    tick_en <= 1'b1;
    repeat (40) @(posedge hclk);
    rd(OFF_COUNTDOWN, 8'h00);
    `CHK(cbr_count, 0)
    mem_in.dram_busy <= 1'b0;
    wait_cbr(1'b1);
    `CHK(n <= 4, 1'b1)
    rst();
    for (int k = 0; k < 2; k++) begin
      logic [7:0] t;
      t = k ? 8'h37 : 8'h12;
      wr(OFF_TIMING, t);
      wr(OFF_CONTROL, 8'h04);
      strobes(2'b00);
      wr(OFF_CONTROL, 8'h00);
      exit_check(t);
    end
    wr(OFF_CONTROL, 8'h08);
    strobes(2'b11);
    mem_in.stop_mode <= 1'b1;
    strobes(2'b00);
    mem_in.stop_mode <= 1'b0;
    strobes(2'b00);
    wr(OFF_CONTROL, 8'h00);
    exit_check(8'h37);
    for (int s = 0; s < 2; s++) begin
      wr(OFF_CONTROL, 8'h0C);
      mem_in.stop_mode <= 1'b1;
      strobes(2'b00);
      mem_in.dram_access <= (s == 0);
      mem_in.bus_release_ack <= (s == 1);
      @(posedge hclk);
      mem_in <= '0;
      exit_check(8'h37);
      rd(OFF_CONTROL, 8'h00);
    end
    tally_and_finish();
  end
endmodule
